/* File: inc/dpd_pkg.sv */
/*
 * Shared constants and types for the dual-port drive extension logic.
 * Assumes a single 100 MHz core clock; all times except SECT_HOLD_NS become cycle counts here.
 */
package dpd_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CLK_KHZ       = CLK_MHZ * 1000;
  localparam int unsigned CLK_NS        = 1000 / CLK_MHZ;
  localparam int unsigned BLANK_US      = 30;
  localparam int unsigned BLANK_CYC     = BLANK_US * CLK_MHZ;
  localparam int unsigned RELEASE_MS    = 500;
  localparam int unsigned RELEASE_CYC   = RELEASE_MS * CLK_KHZ;
  localparam int unsigned PICK_MS       = 10;
  localparam int unsigned PICK_CYC      = PICK_MS * CLK_KHZ;
  localparam int unsigned IFOFF_MS      = 50;
  localparam int unsigned IFOFF_CYC     = IFOFF_MS * CLK_KHZ;
  localparam longint unsigned SPIN_MIN  = 1;
  localparam longint unsigned SPIN_CYC  = SPIN_MIN * 60 * CLK_KHZ * 1000;
  localparam int unsigned SECT_HOLD_NS  = 200;
  localparam int unsigned SECT_NEXT_NS  = 300;
  localparam int unsigned SECT_NEXT_CYC = SECT_NEXT_NS / CLK_NS;
  // ----------------------------------------------------------------
  // bus fields and ports
  // ----------------------------------------------------------------
  localparam int PORT_A      = 0;
  localparam int PORT_B      = 1;
  localparam int BUS_PRI_BIT = 9;
  localparam int HICYL_LSB   = 7;
  localparam int HICYL_W     = 3;
  localparam int HEAD_W      = 7;
  localparam int LOCYL_W     = 10;
  localparam int CYL_W       = LOCYL_W + HICYL_W;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CYL    = 8'h08;
  localparam logic [7:0] REG_SECTOR = 8'h0c;
  localparam int CTRL_INH_BIT   = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_FCLR_BIT  = 2;
  localparam logic [1:0] CTRL_RST    = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       unitSel;
    logic       tag0;
    logic       tag1;
    logic       tag2;
    logic       tag3;
    logic       tag4;
    logic       tag5;
    logic [9:0] busOut;
    logic       pickIn;
    logic       seqDisIn;
    logic       ifEnable;
  } portIn_t;

  typedef struct packed {
    logic       busy;
    logic       seekEnd;
    logic       pickOut;
    logic       seqDisOut;
    logic [7:0] busIn;
  } portOut_t;

  typedef enum logic [1:0] {SP_IDLE, SP_QUAL, SP_SPIN, SP_UP} spin_t;
endpackage

/* File: rtl/dual_port_drive_extensions.sv */
/*
 * Drive-side dual port reservation, spinup sequencing, extended tags
 * and extended cylinder addressing, with an AXI4-Lite register slave.
 * Assumes port lines are asynchronous to core_clk and the drive-side
 * pulses (sector, index, seek end) are already in the core_clk domain.
 */
`timescale 1ns/1ps
module dual_port_drive_extensions #(
  parameter int unsigned     RELEASE_CYC = dpd_pkg::RELEASE_CYC,
  parameter int unsigned     PICK_CYC    = dpd_pkg::PICK_CYC,
  parameter int unsigned     IFOFF_CYC   = dpd_pkg::IFOFF_CYC,
  parameter longint unsigned SPIN_CYC    = dpd_pkg::SPIN_CYC,
  // arbitrary identification value
  parameter logic [7:0]      DEV_ID      = 8'h5a
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic [7:0]                 awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [7:0]                 araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire dpd_pkg::portIn_t           portAIn,
  input  wire dpd_pkg::portIn_t           portBIn,
  output dpd_pkg::portOut_t               portAOut,
  output dpd_pkg::portOut_t               portBOut,
  input  wire logic                       driveSeekEnd,
  input  wire logic                       sectorPulse,
  input  wire logic                       indexPulse,
  input  wire logic                       powerOk,
  input  wire logic                       spunUp,
  input  wire logic [7:0]                 driveStatus,
  output logic                            motorOn,
  output logic                            seekStart,
  output logic [dpd_pkg::CYL_W-1:0]       cylAddr,
  output logic [dpd_pkg::HEAD_W-1:0]      headAddr
);
  localparam int RW = $clog2(RELEASE_CYC + 1);
  localparam int IW = $clog2(IFOFF_CYC + 1);
  localparam int SW = $clog2(SPIN_CYC + 1);
  localparam int BW = $clog2(dpd_pkg::BLANK_CYC + 1);
  localparam int SL = dpd_pkg::SECT_NEXT_CYC;
  localparam int A  = dpd_pkg::PORT_A;
  localparam int B  = dpd_pkg::PORT_B;
  localparam int PB = dpd_pkg::BUS_PRI_BIT;

  // ----------------------------------------------------------------
  // port synchronisers
  // ----------------------------------------------------------------
  dpd_pkg::portIn_t [1:0] s1;
  dpd_pkg::portIn_t [1:0] s2;
  dpd_pkg::portIn_t [1:0] prv;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1  <= '0;
      s2  <= '0;
      prv <= '0;
    end else begin
      s1  <= {portBIn, portAIn};
      s2  <= s1;
      prv <= s2;
    end
  end

  // ----------------------------------------------------------------
  // reservation
  // ----------------------------------------------------------------
  logic [1:0]    hold;
  logic [1:0]    pend;
  logic [1:0]    relArm;
  logic [1:0]    next_hold;
  logic [1:0]    next_pend;
  logic [1:0]    next_relArm;
  logic [1:0]    sel;
  logic [1:0]    priSel;
  logic [1:0]    relCmd;
  logic [1:0]    relDone;
  logic [1:0]    pickOk;
  logic [RW-1:0] relTmr;
  logic [BW-1:0] blank [2];
  logic [1:0]    ctrl;
  logic          timerHit;
  logic          relEvt;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sel[i]     = s2[i].unitSel & s2[i].tag0;
      // edge based, so a held priority select cannot lock out the other
      priSel[i]  = sel[i] & ~prv[i].tag0 & s2[i].busOut[PB];
      relCmd[i]  = sel[i] & s2[i].tag3 & s2[i].busOut[PB] & hold[i];
      relDone[i] = relArm[i] & ~s2[i].tag0;
      pickOk[i]  = s2[i].pickIn & ~s2[i].seqDisIn;
    end
  end

  assign timerHit = ~ctrl[dpd_pkg::CTRL_INH_BIT] & (|hold)
                  & (relTmr == RW'(RELEASE_CYC - 1));

  always_comb begin
    next_hold = hold;
    if (priSel[B]) begin
      next_hold = 2'h2;
    end else if (priSel[A]) begin
      next_hold = 2'h1;
    end else if (relDone[B] & hold[B]) begin
      next_hold = pend[A] ? 2'h1 : 2'h0;
    end else if (relDone[A] & hold[A]) begin
      next_hold = pend[B] ? 2'h2 : 2'h0;
    end else if (timerHit) begin
      if (hold[A]) begin
        next_hold = pend[B] ? 2'h2 : 2'h0;
      end else begin
        next_hold = pend[A] ? 2'h1 : 2'h0;
      end
    end else if (hold == 2'h0) begin
      if (sel[B]) begin
        next_hold = 2'h2;
      end else if (sel[A]) begin
        next_hold = 2'h1;
      end
    end
    relEvt = (|hold) & (next_hold != hold) & ~(|priSel);
    for (int i = 0; i < 2; i++) begin
      next_pend[i] = (hold[1-i] & next_hold[1-i])
                   ? (pend[i] | sel[i]) : 1'b0;
      next_relArm[i] = next_hold[i] & ((relArm[i] & s2[i].tag0) | relCmd[i]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold   <= 2'h0;
      pend   <= 2'h0;
      relArm <= 2'h0;
    end else begin
      hold   <= next_hold;
      pend   <= next_pend;
      relArm <= next_relArm;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      relTmr <= '0;
    end else if (next_hold != hold) begin
      relTmr <= '0;
    end else if ((|hold) & (relTmr != RW'(RELEASE_CYC - 1))) begin
      relTmr <= relTmr + RW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      blank[0] <= '0;
      blank[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (relEvt & pend[i] & hold[1-i]) begin
          blank[i] <= BW'(dpd_pkg::BLANK_CYC);
        end else if (blank[i] != '0) begin
          blank[i] <= blank[i] - BW'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sector count and cylinder address
  // ----------------------------------------------------------------
  logic [7:0]                   sectCnt;
  logic                         prvSect;
  logic                         prvIdx;
  logic [dpd_pkg::HICYL_W-1:0]  hiCyl;
  logic                         hSel;
  logic                         tag1Fall;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sectCnt <= 8'h00;
      prvSect <= 1'b0;
      prvIdx  <= 1'b0;
    end else begin
      prvSect <= sectorPulse;
      prvIdx  <= indexPulse;
      // count moves only on trailing edges, so it holds across pulses
      if (prvIdx & ~indexPulse) begin
        sectCnt <= 8'h00;
      end else if (prvSect & ~sectorPulse) begin
        sectCnt <= sectCnt + 8'h01;
      end
    end
  end

  assign hSel     = hold[B];
  assign tag1Fall = (|hold) & prv[hSel].tag1 & ~s2[hSel].tag1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiCyl     <= '0;
      headAddr  <= '0;
      cylAddr   <= '0;
      seekStart <= 1'b0;
    end else begin
      seekStart <= tag1Fall;
      if ((|hold) & s2[hSel].tag2) begin
        headAddr <= s2[hSel].busOut[dpd_pkg::HEAD_W-1:0];
        hiCyl    <= s2[hSel].busOut[dpd_pkg::HICYL_LSB +:
                                    dpd_pkg::HICYL_W];
      end
      if (tag1Fall) begin
        cylAddr <= {hiCyl,
                    prv[hSel].busOut[dpd_pkg::LOCYL_W-1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // spinup sequencing
  // ----------------------------------------------------------------
  dpd_pkg::spin_t state;
  logic [SW-1:0]  spinCnt;
  logic [IW-1:0]  ifCnt;
  logic           downReq;
  logic           spinFault;
  logic           canRun;
  logic           pass;

  assign downReq = (ifCnt == IW'(IFOFF_CYC));
  assign canRun  = powerOk & ctrl[dpd_pkg::CTRL_START_BIT] & ~downReq;
  assign pass    = ~ctrl[dpd_pkg::CTRL_START_BIT] | ~powerOk
                 | (state == dpd_pkg::SP_UP);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ifCnt <= '0;
    end else if (s2[A].ifEnable | s2[B].ifEnable) begin
      ifCnt <= '0;
    end else if (!downReq) begin
      ifCnt <= ifCnt + IW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= dpd_pkg::SP_IDLE;
      spinCnt <= '0;
    end else begin
      spinCnt <= spinCnt + SW'(1);
      case (state)
        dpd_pkg::SP_IDLE: begin
          spinCnt <= '0;
          if (canRun & (|pickOk)) begin
            state <= dpd_pkg::SP_QUAL;
          end
        end
        dpd_pkg::SP_QUAL: begin
          if (!canRun || pickOk == 2'h0) begin
            state <= dpd_pkg::SP_IDLE;
          end else if (spinCnt == SW'(PICK_CYC - 1)) begin
            state   <= dpd_pkg::SP_SPIN;
            spinCnt <= '0;
          end
        end
        dpd_pkg::SP_SPIN: begin
          if (!canRun) begin
            state <= dpd_pkg::SP_IDLE;
          end else if (spunUp) begin
            state <= dpd_pkg::SP_UP;
          end else if (spinCnt == SW'(SPIN_CYC - 1)) begin
            state <= dpd_pkg::SP_IDLE;
          end
        end
        dpd_pkg::SP_UP: begin
          if (!canRun) begin
            state <= dpd_pkg::SP_IDLE;
          end
        end
        default: state <= dpd_pkg::SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      motorOn <= 1'b0;
    end else begin
      motorOn <= (state == dpd_pkg::SP_SPIN) | (state == dpd_pkg::SP_UP);
    end
  end

  // ----------------------------------------------------------------
  // port outputs
  // ----------------------------------------------------------------
  dpd_pkg::portOut_t [1:0] outQ;
  dpd_pkg::portOut_t [1:0] next_out;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_out[i].busy    = sel[i] & hold[1-i];
      next_out[i].seekEnd = hold[1-i] | ((blank[i] == '0) & driveSeekEnd);
      next_out[i].seqDisOut = (state == dpd_pkg::SP_SPIN);
      next_out[i].pickOut = pass & s2[i].pickIn;
      next_out[i].busIn   = 8'h00;
      if (sel[i] & ~hold[1-i]) begin
        case ({s2[i].tag5, s2[i].tag4})
          2'h1:    next_out[i].busIn = sectCnt;
          2'h2:    next_out[i].busIn = driveStatus;
          2'h3:    next_out[i].busIn = DEV_ID;
          default: next_out[i].busIn = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      outQ <= '0;
    end else begin
      outQ <= next_out;
    end
  end

  assign portAOut = outQ[A];
  assign portBOut = outQ[B];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        doWrite;
  logic        ctrlHit;
  logic [31:0] rdNext;
  logic        rdOk;

  assign doWrite = ~awready & ~wready & ~bvalid;
  assign ctrlHit = doWrite & (awAddrQ == dpd_pkg::REG_CTRL) & wStrbQ[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= dpd_pkg::RESP_OKAY;
      awAddrQ <= 8'h00;
      wDataQ  <= 32'h0;
      wStrbQ  <= 4'h0;
    end else begin
      if (awvalid & awready) begin
        awready <= 1'b0;
        awAddrQ <= awaddr;
      end
      if (wvalid & wready) begin
        wready <= 1'b0;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= (awAddrQ == dpd_pkg::REG_CTRL) ? dpd_pkg::RESP_OKAY
                                                 : dpd_pkg::RESP_SLVERR;
      end else if (bvalid & bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl      <= dpd_pkg::CTRL_RST;
      spinFault <= 1'b0;
    end else begin
      if (ctrlHit) begin
        ctrl <= wDataQ[1:0];
      end
      // a timeout in the clearing cycle still lands
      if ((state == dpd_pkg::SP_SPIN) & ~spunUp
          & (spinCnt == SW'(SPIN_CYC - 1))) begin
        spinFault <= 1'b1;
      end else if (ctrlHit & wDataQ[dpd_pkg::CTRL_FCLR_BIT]) begin
        spinFault <= 1'b0;
      end
    end
  end

  always_comb begin
    rdOk   = 1'b1;
    rdNext = 32'h0;
    case (araddr)
      dpd_pkg::REG_CTRL:   rdNext = {30'h0, ctrl};
      dpd_pkg::REG_STATUS: rdNext = {24'h0, downReq, spinFault,
                                     state, pend, hold};
      dpd_pkg::REG_CYL:    rdNext = {12'h0, headAddr, cylAddr};
      dpd_pkg::REG_SECTOR: rdNext = {24'h0, sectCnt};
      default:             rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= dpd_pkg::RESP_OKAY;
    end else if (arvalid & arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdNext;
      rresp   <= rdOk ? dpd_pkg::RESP_OKAY : dpd_pkg::RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_busy_opposite: assert property (sel[A] && hold[B] |=> portAOut.busy)
    else $error("busy not shown to port A");
  a_seek_nonhold: assert property (hold[A] |=> portBOut.seekEnd)
    else $error("seek end not forced to port B");
  a_seek_blank: assert property ($rose(blank[B] != '0)
      |=> !portBOut.seekEnd [*8])
    else $error("seek end not blanked after release");
  a_hold_exclusive: assert property (hold != 2'h3)
    else $error("both ports hold the drive");
  a_pri_wins: assert property (priSel[B] |=> hold == 2'h2)
    else $error("priority select B did not take hold");
  a_release_wait: assert property (relArm[A] && s2[A].tag0
      && priSel == 2'h0 && !timerHit |=> hold[A])
    else $error("hold dropped before TAG 0 fell");
  a_timer_release: assert property (hold == 2'h1 && pend == 2'h0
      && timerHit && priSel == 2'h0 && !relDone[A]
      |=> hold == 2'h0)
    else $error("timer failed to release");
  a_spin_disable: assert property (state == dpd_pkg::SP_SPIN
      |=> portAOut.seqDisOut && !portBOut.pickOut)
    else $error("spinup outputs wrong");
  a_pick_pass: assert property (state == dpd_pkg::SP_UP
      |=> portAOut.pickOut == $past(s2[A].pickIn))
    else $error("pick not passed after spinup");
  a_sector_hold: assert property (sectorPulse && (indexPulse || !prvIdx)
      |=> $stable(sectCnt))
    else $error("sector count moved during pulse");
  a_sector_next: assert property ($fell(indexPulse)
      |-> ##[1:SL] sectCnt == 8'h00)
    else $error("sector count not cleared after index");
  a_seek_fall: assert property (tag1Fall |=> seekStart)
    else $error("seek not started on TAG 1 fall");

endmodule // dual_port_drive_extensions

/* File: test/ctrl_unit_pair.sv */
/*
 * Two control units on port A and port B of one drive.
 * Assumes core_clk; every line changes just after a rising edge.
 */
`timescale 1ns/1ps
module ctrl_unit_pair (
  input  wire logic        core_clk,
  output dpd_pkg::portIn_t portAIn,
  output dpd_pkg::portIn_t portBIn
);
  dpd_pkg::portIn_t p [2] = '{20'h00001, 20'h00001};
  assign portAIn = p[0];
  assign portBIn = p[1];
  // ----
  // line sequences
  // ----
  // six cycles a step so both sync stages settle
  task automatic wait6;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic sel(input logic [1:0] m, input logic pri);
    @(posedge core_clk);
    for (int b = 0; b < 2; b++) if (m[b]) begin
      p[b].unitSel <= 1'h1;
      p[b].tag0    <= 1'h1;
      p[b].busOut  <= {pri, 9'h000};
    end
    wait6();
  endtask
  task automatic desel(input logic [1:0] m);
    @(posedge core_clk);
    for (int b = 0; b < 2; b++) if (m[b]) begin
      p[b].unitSel <= 1'h0;
      p[b].tag0    <= 1'h0;
      // released bus shows no stale value
      p[b].busOut  <= ~p[b].busOut;
    end
    wait6();
  endtask
  task automatic rel(input logic [1:0] m);
    @(posedge core_clk);
    for (int b = 0; b < 2; b++) if (m[b]) begin
      p[b].tag3   <= 1'h1;
      p[b].busOut <= 10'h200;
    end
    wait6();
    for (int b = 0; b < 2; b++) if (m[b]) begin
      p[b].tag3 <= 1'h0;
    end
    wait6();
    desel(m);
  endtask
  task automatic tags(input logic [1:0] m, input logic t4, input logic t5);
    @(posedge core_clk);
    for (int b = 0; b < 2; b++) if (m[b]) begin
      p[b].tag4 <= t4;
      p[b].tag5 <= t5;
    end
    wait6();
  endtask
  task automatic pick(input logic [1:0] m, input logic v);
    @(posedge core_clk);
    for (int b = 0; b < 2; b++) if (m[b]) begin
      p[b].pickIn <= v;
    end
    wait6();
  endtask
  task automatic seek(input logic [12:0] cyl, input logic [6:0] hd);
    @(posedge core_clk);
    p[0].tag2   <= 1'h1;
    p[0].busOut <= {cyl[12:10], hd};
    wait6();
    p[0].tag2   <= 1'h0;
    wait6();
    p[0].tag1   <= 1'h1;
    p[0].busOut <= cyl[9:0];
    wait6();
    p[0].tag1   <= 1'h0;
    p[0].busOut <= ~cyl[9:0];
  endtask
endmodule // ctrl_unit_pair

/* File: test/test_dual_port_drive_extensions.sv */
/*
 * Self-checking bench for the dual-port drive extension block.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ps
module test_dual_port_drive_extensions;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic core_clk = 1'h0, rst_b = 1'h0, sectorPulse = 1'h0;
  logic driveSeekEnd = 1'h1, indexPulse = 1'h0, powerOk = 1'h1;
  logic spunUp = 1'h0;
  logic [3:0]  wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, stat = 8'h00;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, seekStart, motorOn;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [12:0] cyl, cylAddr;
  logic [6:0]  head, headAddr;
  logic [65:0] e;
  logic [65:0] expQ [$];
  int          bad_count = 0, checks_done = 0, cycles = 0;
  dpd_pkg::portIn_t  portAIn, portBIn;
  dpd_pkg::portOut_t portAOut, portBOut;
  dual_port_drive_extensions #(.RELEASE_CYC(200), .PICK_CYC(50),
    .IFOFF_CYC(60), .SPIN_CYC(300), .DEV_ID(ID)) dut (
    .core_clk, .rst_b, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .portAIn, .portBIn, .portAOut, .portBOut, .driveSeekEnd,
    .sectorPulse, .indexPulse, .powerOk, .spunUp,
    .driveStatus(stat), .motorOn, .seekStart, .cylAddr, .headAddr);
  ctrl_unit_pair cu (.core_clk, .portAIn, .portBIn);
  // ----
  // checking
  // ----
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      print_verdict();
    end
  end
  // answers are compared against the oldest note in the queue
  always @(posedge core_clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      e = expQ.pop_front();
      chk({rvalid ? rresp : bresp, rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
  end
  // ----
  // register bus
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    expQ.push_back({r, 64'h0});
    @(posedge core_clk);
    awaddr  <= a;
    awprot  <= 3'($urandom);
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, m, d});
    @(posedge core_clk);
    araddr  <= a;
    arprot  <= 3'($urandom);
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask
  task automatic st(input logic [31:0] d);
    rd(dpd_pkg::REG_STATUS, 32'h3, d, 2'h0);
  endtask
  initial begin
    void'($urandom(69842));
    cyl  = 13'($urandom);
    head = 7'($urandom);
    @(posedge core_clk);
    stat <= 8'($urandom);
    repeat (8) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge core_clk);
    rd(dpd_pkg::REG_CTRL, 32'h7, 32'h1, 2'h0);
    rd(8'h10, 32'hffffffff, 32'h0, 2'h2);
    wr(8'h10, 32'h1, 2'h2);
    repeat (3) begin
      sectorPulse <= 1'h1;
      @(posedge core_clk);
      sectorPulse <= 1'h0;
      @(posedge core_clk);
    end
    cu.pick(2'h1, 1'h1);
    chk(34'(portAOut.pickOut), 34'h1);
    cu.sel(2'h1, 1'h0);
    st(32'h1);
    cu.sel(2'h2, 1'h0);
    chk(34'(portBOut.busy), 34'h1);
    chk(34'(portBOut.seekEnd), 34'h1);
    cu.rel(2'h1);
    chk(34'(portBOut.seekEnd), 34'h0);
    st(32'h2);
    repeat (3010) @(posedge core_clk);
    chk(34'(portBOut.seekEnd), 34'h1);
    cu.sel(2'h1, 1'h1);
    st(32'h1);
    cu.desel(2'h2);
    cu.sel(2'h2, 1'h1);
    st(32'h2);
    cu.desel(2'h3);
    cu.sel(2'h3, 1'h1);
    st(32'h2);
    cu.desel(2'h3);
    st(32'h2);
    wr(dpd_pkg::REG_CTRL, 32'h0, 2'h0);
    // A tried during B's hold, so the timer hands the hold over first
    repeat (250) @(posedge core_clk);
    st(32'h1);
    repeat (200) @(posedge core_clk);
    st(32'h0);
    cu.sel(2'h1, 1'h0);
    wr(dpd_pkg::REG_CTRL, 32'h1, 2'h0);
    repeat (250) @(posedge core_clk);
    st(32'h1);
    cu.tags(2'h1, 1'h1, 1'h0);
    chk(34'(portAOut.busIn), 34'h3);
    cu.tags(2'h1, 1'h0, 1'h1);
    chk(34'(portAOut.busIn), 34'(stat));
    cu.tags(2'h1, 1'h1, 1'h1);
    chk(34'(portAOut.busIn), 34'(ID));
    cu.tags(2'h1, 1'h0, 1'h0);
    indexPulse <= 1'h1;
    repeat (2) @(posedge core_clk);
    indexPulse <= 1'h0;
    rd(dpd_pkg::REG_SECTOR, 32'hff, 32'h0, 2'h0);
    cu.seek(cyl, head);
    for (int i = 0; i < 20 && seekStart !== 1'h1; i++) @(posedge core_clk);
    chk(34'(seekStart), 34'h1);
    chk(34'(cylAddr), 34'(cyl));
    rd(dpd_pkg::REG_CYL, 32'hfffff, 32'({head, cyl}), 2'h0);
    powerOk <= 1'h0;
    wr(dpd_pkg::REG_CTRL, 32'h3, 2'h0);
    repeat (60) @(posedge core_clk);
    chk(34'({motorOn, portAOut.pickOut}), 34'h1);
    powerOk <= 1'h1;
    repeat (20) @(posedge core_clk);
    rd(dpd_pkg::REG_STATUS, 32'h30, 32'h10, 2'h0);
    repeat (40) @(posedge core_clk);
    chk(34'({portBOut.seqDisOut, portAOut.pickOut, motorOn}), 34'h5);
    spunUp <= 1'h1;
    repeat (6) @(posedge core_clk);
    chk(34'({portBOut.seqDisOut, portAOut.pickOut}), 34'h1);
    cu.p[0].ifEnable <= 1'h0;
    cu.p[1].ifEnable <= 1'h0;
    repeat (70) @(posedge core_clk);
    rd(dpd_pkg::REG_STATUS, 32'hf0, 32'h80, 2'h0);
    // let the answer checker take the last note first
    @(posedge core_clk);
    if (expQ.size() != 0) bad_count++;
    print_verdict();
  end
endmodule // test_dual_port_drive_extensions
